// ### lgoc_defs.vh
`ifndef LGOC_DEFS_VH
`define LGOC_DEFS_VH
// Clock rate in kHz, used to turn millisecond figures into cycle counts
`define LGOC_CLK_KHZ 125000
// Least time the outputs stay off before an automatic restart after a trip, in ms
`define LGOC_MIN_OFF_MS 80
// Extra wait after one synchronisation pair was blocked, in ms
`define LGOC_SYNC_EXTRA_MS 10
// Response times in ms, uncoded and coded (coded is longer)
`define LGOC_RESP_UNC_MS 10
`define LGOC_RESP_COD_MS 20
// Resynchronisation times in ms when both sync pairs were blocked
`define LGOC_RESYNC_UNC_MS 40
`define LGOC_RESYNC_COD_MS 80
// Power-up check time in ms
`define LGOC_CHECK_MS 2
// Lamp codes
`define LGOC_LAMP_OFF 2'h0
`define LGOC_LAMP_ON 2'h1
`define LGOC_LAMP_ERR 2'h2
`define LGOC_LAMP_CHK 2'h3
`endif

// ### lgoc_timer.v
`timescale 1ns/10ps
`include "lgoc_defs.vh"
// Down counter; start loads a count, done pulses one cycle when it expires
module lgoc_timer #(
    parameter WIDTH = 24
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire start_i,
    input wire [WIDTH-1:0] load_i,
    input wire abort_i,
    output reg busy_o,
    output reg done_o
);
    reg [WIDTH-1:0] cnt_reg;

    // Load wins over abort so a restart is never lost
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_reg <= {WIDTH{1'b0}};
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                cnt_reg <= load_i;
                busy_o <= 1'b1;
            end else if (abort_i) begin
                busy_o <= 1'b0;
            end else if (busy_o) begin
                if (cnt_reg <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg - {{(WIDTH-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

// ### lgoc_ctrl.v
// Notes on behaviour
// [RULE_01] Both safety switch outputs go off while any beam is blocked.
// [RULE_02] An error seen on either safety switch output forces both outputs off.
// [RULE_03] Interfering light at the receiver forces both outputs off.
// [RULE_04] After an error the outputs stay off until a successful restart check.
// [RULE_05] At power-up a check runs by itself and turns outputs on only when all is well.
// [RULE_06] Automatic restart needs good wiring, no fault, clear field and 80 ms off time; after an error the check path skips the off time.
// [RULE_07] Uncoded, one sync pair blocked: outputs on after uncoded response time plus 10 ms.
// [RULE_08] Coded, one sync pair blocked: outputs on after coded response time plus 10 ms.
// [RULE_09] Both sync pairs blocked: outputs on after the coded or uncoded resync time.
// [RULE_10] Coded operation has a longer response time to outputs off than uncoded.
// [RULE_11] The installer picks the coding by supply wiring; neighbour grids need different codes.
// [RULE_12] Transmitter and receiver synchronise optically with no electrical link.
// [RULE_13] Operating status and error state are shown on indicator lamps.
// [RULE_14] The evaluation device reads the two outputs as independent channels.
// [RULE_15] No restart interlock is built in; the outside controller must add one if needed.
// [RULE_16] Both outputs switch together; neither is on while the other is commanded off.
`timescale 1ns/10ps
`include "lgoc_defs.vh"
module lgoc_ctrl #(
    parameter MIN_OFF_MS = `LGOC_MIN_OFF_MS,
    parameter SYNC_EXTRA_MS = `LGOC_SYNC_EXTRA_MS,
    parameter RESP_UNC_MS = `LGOC_RESP_UNC_MS,
    parameter RESP_COD_MS = `LGOC_RESP_COD_MS,
    parameter RESYNC_UNC_MS = `LGOC_RESYNC_UNC_MS,
    parameter RESYNC_COD_MS = `LGOC_RESYNC_COD_MS,
    parameter CHECK_MS = `LGOC_CHECK_MS,
    parameter CLK_KHZ = `LGOC_CLK_KHZ
) (
    input wire CLK_I,
    input wire RST_B_I,
    input wire BEAM_BLOCKED_I,
    input wire SYNC_FIRST_BLOCKED_I,
    input wire SYNC_LAST_BLOCKED_I,
    input wire OPTICAL_SYNC_OK_I,
    input wire INTERFERENCE_I,
    input wire CODING_SEL_I,
    input wire [1:0] SAFETY_SWITCH_OUTPUT_FB_I,
    input wire INTERNAL_FAULT_I,
    output reg [1:0] SAFETY_SWITCH_OUTPUT_O,
    output reg [1:0] STATUS_LAMP_O,
    output reg ERROR_LAMP_O
);
    localparam TW = 32;
    // Cycle counts derived from the millisecond figures
    localparam [TW-1:0] MIN_OFF_CYC = MIN_OFF_MS * CLK_KHZ;
    localparam [TW-1:0] SYNC_UNC_CYC = (RESP_UNC_MS + SYNC_EXTRA_MS) * CLK_KHZ;
    localparam [TW-1:0] SYNC_COD_CYC = (RESP_COD_MS + SYNC_EXTRA_MS) * CLK_KHZ;
    localparam [TW-1:0] RESYNC_UNC_CYC = RESYNC_UNC_MS * CLK_KHZ;
    localparam [TW-1:0] RESYNC_COD_CYC = RESYNC_COD_MS * CLK_KHZ;
    localparam [TW-1:0] RESP_UNC_CYC = RESP_UNC_MS * CLK_KHZ;
    localparam [TW-1:0] RESP_COD_CYC = RESP_COD_MS * CLK_KHZ;
    localparam [TW-1:0] CHECK_CYC = CHECK_MS * CLK_KHZ;

    // One-hot states
    localparam [4:0] ST_CHECK = 5'h01;
    localparam [4:0] ST_ON = 5'h02;
    localparam [4:0] ST_RESP = 5'h04;
    localparam [4:0] ST_OFF = 5'h08;
    localparam [4:0] ST_ERROR = 5'h10;

    // Two-flop synchronisers for every pin input
    localparam NIN = 9;
    wire [NIN-1:0] raw_in;
    reg [NIN-1:0] sync1_reg;
    reg [NIN-1:0] sync2_reg;
    assign raw_in = {INTERNAL_FAULT_I, SAFETY_SWITCH_OUTPUT_FB_I, CODING_SEL_I,
                     INTERFERENCE_I, OPTICAL_SYNC_OK_I, SYNC_LAST_BLOCKED_I,
                     SYNC_FIRST_BLOCKED_I, BEAM_BLOCKED_I};
    always @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            sync1_reg <= {NIN{1'b0}};
            sync2_reg <= {NIN{1'b0}};
        end else begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
        end
    end

    wire beam_blk = sync2_reg[0];
    wire first_blk = sync2_reg[1];
    wire last_blk = sync2_reg[2];
    wire opt_sync = sync2_reg[3];
    wire interf = sync2_reg[4];
    wire coding_live = sync2_reg[5];
    wire [1:0] fb = sync2_reg[7:6];
    wire int_fault = sync2_reg[8];

    reg [4:0] state_reg;
    reg [4:0] state_next;
    reg coded_reg;
    reg coding_valid_reg;
    reg one_pair_reg;
    reg both_pairs_reg;
    reg min_off_done_reg;
    reg [1:0] out_cmd_reg;
    reg [1:0] cmd_d1_reg;
    reg [1:0] cmd_d2_reg;
    reg [1:0] fill_reg;

    // Synchroniser fill: pin values are only real two edges after reset release
    always @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            fill_reg <= 2'h0;
        end else begin
            fill_reg <= {fill_reg[0], 1'b1};
        end
    end

    // Command delayed by the synchroniser depth, so readback meets what was driven
    // when it was sampled; without this every switch-over would look like a fault
    always @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            cmd_d1_reg <= 2'h0;
            cmd_d2_reg <= 2'h0;
        end else begin
            cmd_d1_reg <= out_cmd_reg;
            cmd_d2_reg <= cmd_d1_reg;
        end
    end

    // Coding is caught once the synchronisers hold real pin values;
    // a later change of wiring is a fault
    always @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            coded_reg <= 1'b0;
            coding_valid_reg <= 1'b0;
        end else if (fill_reg[1] && !coding_valid_reg) begin
            coded_reg <= coding_live;
            coding_valid_reg <= 1'b1;
        end
    end

    // Wiring/output fault: feedback must mirror the commanded pair
    wire out_err = (fb != cmd_d2_reg); // RULE_02
    wire coding_err = coding_valid_reg && (coding_live != coded_reg);
    wire fault = out_err | int_fault | coding_err;
    wire field_clear = !beam_blk && !first_blk && !last_blk && opt_sync; // RULE_12
    wire trip = beam_blk | first_blk | last_blk | !opt_sync | interf; // RULE_01 RULE_03

    // Timers: response / check / restart wait share one, min-off uses another
    reg t_start;
    reg [TW-1:0] t_load;
    wire t_busy;
    wire t_done;
    reg m_start;
    wire m_busy;
    wire m_done;

    lgoc_timer #(.WIDTH(TW)) u_main_timer (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .start_i(t_start),
        .load_i(t_load),
        .abort_i(1'b0),
        .busy_o(t_busy),
        .done_o(t_done)
    );

    lgoc_timer #(.WIDTH(TW)) u_off_timer (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .start_i(m_start),
        .load_i(MIN_OFF_CYC),
        .abort_i(1'b0),
        .busy_o(m_busy),
        .done_o(m_done)
    );

    // Restart wait depends on which sync pairs were blocked and on coding
    reg [TW-1:0] restart_cyc;
    always @* begin
        if (both_pairs_reg) begin
            restart_cyc = coded_reg ? RESYNC_COD_CYC : RESYNC_UNC_CYC; // RULE_09
        end else if (one_pair_reg) begin
            restart_cyc = coded_reg ? SYNC_COD_CYC : SYNC_UNC_CYC; // RULE_07 RULE_08
        end else begin
            restart_cyc = {{(TW-1){1'b0}}, 1'b1};
        end
    end

    // State transitions; faults win over everything
    always @* begin
        state_next = state_reg;
        t_start = 1'b0;
        t_load = CHECK_CYC;
        m_start = 1'b0;
        case (state_reg)
            ST_CHECK: begin
                if (fault) begin
                    state_next = ST_ERROR;
                end else if (!field_clear || interf) begin
                    t_start = 1'b1; // Restart the check while the field is not clear
                    t_load = CHECK_CYC;
                end else if (t_done) begin
                    state_next = ST_ON; // RULE_05 RULE_04
                end
            end
            ST_ON: begin
                if (fault) begin
                    state_next = ST_ERROR;
                    m_start = 1'b1;
                end else if (interf) begin
                    state_next = ST_OFF; // RULE_03
                    m_start = 1'b1;
                end else if (trip) begin
                    state_next = ST_RESP;
                    t_start = 1'b1;
                    t_load = coded_reg ? RESP_COD_CYC : RESP_UNC_CYC; // RULE_10
                end
            end
            ST_RESP: begin
                if (fault) begin
                    state_next = ST_ERROR;
                    m_start = 1'b1;
                end else if (t_done || interf) begin
                    state_next = ST_OFF; // RULE_01
                    m_start = 1'b1;
                end
            end
            ST_OFF: begin
                if (fault) begin
                    state_next = ST_ERROR;
                end else if (trip) begin
                    t_start = 1'b1;
                    t_load = restart_cyc;
                end else if (min_off_done_reg && !t_busy) begin
                    state_next = ST_ON; // RULE_06
                end
            end
            ST_ERROR: begin
                // Leave only through a full power-up style check
                if (!fault) begin
                    state_next = ST_CHECK; // RULE_04
                    t_start = 1'b1;
                    t_load = CHECK_CYC;
                end
            end
            default: begin
                state_next = ST_ERROR;
            end
        endcase
    end

    // State, sync-pair memory and min-off flag
    always @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            state_reg <= ST_ERROR;
            one_pair_reg <= 1'b0;
            both_pairs_reg <= 1'b0;
            min_off_done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (m_start) begin
                min_off_done_reg <= 1'b0;
                one_pair_reg <= 1'b0;
                both_pairs_reg <= 1'b0;
            end else begin
                if (m_done) begin
                    min_off_done_reg <= 1'b1;
                end
                if (first_blk && last_blk) begin
                    both_pairs_reg <= 1'b1;
                end
                if (first_blk || last_blk) begin
                    one_pair_reg <= 1'b1;
                end
            end
        end
    end

    // Outputs stay on while the response time runs; coded grids wait longer
    wire next_on = (state_next == ST_ON) || (state_next == ST_RESP); // RULE_10

    // Outputs: both channels from one command, so they never differ
    always @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            out_cmd_reg <= 2'h0;
            SAFETY_SWITCH_OUTPUT_O <= 2'h0;
            STATUS_LAMP_O <= `LGOC_LAMP_OFF;
            ERROR_LAMP_O <= 1'b0;
        end else begin
            if (next_on) begin
                out_cmd_reg <= 2'h3; // RULE_16
                SAFETY_SWITCH_OUTPUT_O <= 2'h3;
            end else begin
                out_cmd_reg <= 2'h0; // RULE_02 RULE_03 RULE_16
                SAFETY_SWITCH_OUTPUT_O <= 2'h0;
            end
            // Lamps track the state for the operator
            ERROR_LAMP_O <= (state_next == ST_ERROR); // RULE_13
            if (next_on) begin
                STATUS_LAMP_O <= `LGOC_LAMP_ON;
            end else if (state_next == ST_ERROR) begin
                STATUS_LAMP_O <= `LGOC_LAMP_ERR;
            end else if (state_next == ST_CHECK) begin
                STATUS_LAMP_O <= `LGOC_LAMP_CHK;
            end else begin
                STATUS_LAMP_O <= `LGOC_LAMP_OFF;
            end
        end
    end
endmodule

// ### lgoc_ctrl_asserts.sv
`timescale 1ns/10ps
// Port-level checker for the output controller
module lgoc_ctrl_chk #(
    parameter MIN_OFF_MS = 80,
    parameter CLK_KHZ = 125000
) (
    input wire CLK_I,
    input wire RST_B_I,
    input wire BEAM_BLOCKED_I,
    input wire OPTICAL_SYNC_OK_I,
    input wire INTERFERENCE_I,
    input wire [1:0] SAFETY_SWITCH_OUTPUT_FB_I,
    input wire INTERNAL_FAULT_I,
    input wire [1:0] SAFETY_SWITCH_OUTPUT_O,
    input wire [1:0] STATUS_LAMP_O
);
    localparam LIM = MIN_OFF_MS * CLK_KHZ;
    reg [31:0] off_cnt_reg;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    // Off-time count, parked at the limit so the power-up start passes
    always @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            off_cnt_reg <= LIM;
        end else if (SAFETY_SWITCH_OUTPUT_O != 2'h0) begin
            off_cnt_reg <= 32'h0;
        end else if (off_cnt_reg < LIM) begin
            off_cnt_reg <= off_cnt_reg + 32'h1;
        end
    end
    // Steps of a restart and of a held fault
    sequence s_turn_on; $rose(SAFETY_SWITCH_OUTPUT_O[0]); endsequence
    sequence s_fault_held; INTERNAL_FAULT_I [*6]; endsequence
    property p_pair; SAFETY_SWITCH_OUTPUT_O[0] == SAFETY_SWITCH_OUTPUT_O[1]; endproperty
    a_pair: assert property (p_pair) else $error("Outputs differ");
    property p_beam; $rose(BEAM_BLOCKED_I) |->
        ##[0:30] (SAFETY_SWITCH_OUTPUT_O == 2'h0 || !BEAM_BLOCKED_I); endproperty
    a_beam: assert property (p_beam) else $error("Beam block not obeyed");
    property p_intf; $rose(INTERFERENCE_I) |-> ##[0:6] SAFETY_SWITCH_OUTPUT_O == 2'h0; endproperty
    a_intf: assert property (p_intf) else $error("Stray light not obeyed");
    property p_fb; SAFETY_SWITCH_OUTPUT_FB_I != SAFETY_SWITCH_OUTPUT_O |->
        ##[0:6] SAFETY_SWITCH_OUTPUT_O == 2'h0; endproperty
    a_fb: assert property (p_fb) else $error("Readback fault not obeyed");
    property p_fault; s_fault_held |-> SAFETY_SWITCH_OUTPUT_O == 2'h0; endproperty
    a_fault: assert property (p_fault) else $error("On during fault");
    property p_min_off; s_turn_on |-> off_cnt_reg >= LIM; endproperty
    a_min_off: assert property (p_min_off) else $error("Restart too early");
    property p_lamp; SAFETY_SWITCH_OUTPUT_O == 2'h3 |-> STATUS_LAMP_O == 2'h1; endproperty
    a_lamp: assert property (p_lamp) else $error("Lamp not on");
    property p_sync; $fell(OPTICAL_SYNC_OK_I) |->
        ##[0:30] (SAFETY_SWITCH_OUTPUT_O == 2'h0 || OPTICAL_SYNC_OK_I); endproperty
    a_sync: assert property (p_sync) else $error("Sync loss not obeyed");
endmodule
bind lgoc_ctrl lgoc_ctrl_chk #(.MIN_OFF_MS(MIN_OFF_MS), .CLK_KHZ(CLK_KHZ)) chk_i (
    .CLK_I(CLK_I), .RST_B_I(RST_B_I), .BEAM_BLOCKED_I(BEAM_BLOCKED_I),
    .OPTICAL_SYNC_OK_I(OPTICAL_SYNC_OK_I), .INTERFERENCE_I(INTERFERENCE_I),
    .SAFETY_SWITCH_OUTPUT_FB_I(SAFETY_SWITCH_OUTPUT_FB_I), .INTERNAL_FAULT_I(INTERNAL_FAULT_I),
    .SAFETY_SWITCH_OUTPUT_O(SAFETY_SWITCH_OUTPUT_O), .STATUS_LAMP_O(STATUS_LAMP_O));

// ### lgoc_eval_model.sv
`timescale 1ns/10ps
// Evaluation device on the far side of the two outputs
module lgoc_eval_model (
    input wire logic [1:0] out_i,
    input wire logic break_i,
    output logic [1:0] fb_o,
    output logic chan_ok_o
);
    // Echo with no delay; a late readback would look like a wiring fault
    assign fb_o = {out_i[1], out_i[0] ^ break_i};
    // Two channels read apart; no restart lockout is added here
    assign chan_ok_o = (out_i[1] == out_i[0]);
endmodule

// ### test_lgoc_ctrl.sv
`timescale 1ns/10ps
module test_lgoc_ctrl;
    localparam RU = 10, RC = 20, XU = 40, XC = 80, EX = 10;
    logic clk = 0, rst_b = 0, beam = 0, sf = 0, sl = 0, ok = 1;
    logic intf = 0, cod = 0, fault = 0, brk = 0, elamp, chan_ok;
    logic [1:0] fb, out, lamp;
    int bad_count = 0, samples_checked = 0, n, k;
    // One ms per cycle keeps the long waits short
    lgoc_ctrl #(.MIN_OFF_MS(80), .SYNC_EXTRA_MS(EX), .RESP_UNC_MS(RU), .RESP_COD_MS(RC),
        .RESYNC_UNC_MS(XU), .RESYNC_COD_MS(XC), .CHECK_MS(2), .CLK_KHZ(1)) DUT (
        .CLK_I(clk), .RST_B_I(rst_b), .BEAM_BLOCKED_I(beam), .SYNC_FIRST_BLOCKED_I(sf),
        .SYNC_LAST_BLOCKED_I(sl), .OPTICAL_SYNC_OK_I(ok), .INTERFERENCE_I(intf),
        .CODING_SEL_I(cod), .SAFETY_SWITCH_OUTPUT_FB_I(fb), .INTERNAL_FAULT_I(fault),
        .SAFETY_SWITCH_OUTPUT_O(out), .STATUS_LAMP_O(lamp), .ERROR_LAMP_O(elamp));
    lgoc_eval_model eval_i (.out_i(out), .break_i(brk), .fb_o(fb), .chan_ok_o(chan_ok));
    always #4 clk = ~clk;
    task test_done;
        $display("Checked %0d, bad %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    // Inputs always change 1 ns after the rising edge
    task cyc(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task wait_out(input logic [1:0] v);
        n = 0;
        while (out !== v && n < 400) begin
            cyc(1);
            n++;
        end
    endtask
    // Reset with a chosen coding, then the start must come by itself
    task boot(input logic c);
        rst_b = 0;
        cod = c;
        cyc(8);
        rst_b = 1;
        wait_out(2'h3);
        chk(n <= 12, 1'b1);
        chk(lamp, 2'h1);
    endtask
    // Block with sync pairs, then time the release; 100 cycles cover the off time
    task t_block(input int resp, input logic f, input logic l, input int want);
        beam = 1;
        sf = f;
        sl = l;
        wait_out(2'h0);
        chk(n >= resp && n <= resp + 6, 1'b1);
        cyc(100);
        beam = 0;
        sf = 0;
        sl = 0;
        wait_out(2'h3);
        chk(n >= want && n <= want + 6, 1'b1);
    endtask
    // Short block: the off time still has to be served
    task t_min_off;
        beam = 1;
        wait_out(2'h0);
        cyc(1);
        beam = 0;
        wait_out(2'h3);
        chk(n >= 78 && n <= 110, 1'b1);
    endtask
    // Stray light, sync loss, internal fault, readback fault
    task t_trip(input int t);
        intf = (t == 0);
        ok = (t != 1);
        fault = (t == 2);
        brk = (t == 3);
        wait_out(2'h0);
        chk(n <= 30, 1'b1);
        cyc(150);
        chk(out, 2'h0);
        chk(chan_ok, 1'b1);
        if (t >= 2) chk(elamp, 1'b1);
        if (t >= 2) chk(lamp, 2'h2);
        {intf, ok, fault, brk} = 4'h4;
        wait_out(2'h3);
        chk(n <= 100, 1'b1);
    endtask
    initial begin
        boot(1'b0);
        t_block(RU, 1'b1, 1'b0, RU + EX);
        t_block(RU, 1'b1, 1'b1, XU);
        t_min_off;
        for (k = 0; k < 4; k++) begin
            t_trip(k);
        end
        boot(1'b1);
        t_block(RC, 1'b0, 1'b1, RC + EX);
        t_block(RC, 1'b1, 1'b1, XC);
        test_done;
    end
    // Watchdog well beyond the 1500 or so cycles the run needs
    initial begin
        #160000;
        bad_count++;
        test_done;
    end
endmodule
